// *** tnc_decoder.sv ***
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`include "tnc_regs.svh"
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// RQ1 - Interrupt-clear codes are acted on only while command chaining is on.
// RQ2 - Disable-transmit cancels an armed transmission not yet sending.
// RQ3 - After disable-transmit, next token sets transmitter available.
// RQ4 - Disable-receive cancels any armed receive.
// RQ5 - Disable-receive while idle sets receiver inhibited at next token.
// RQ6 - Disable-receive during reception lets that reception finish.
// RQ7 - Enable-receive: page in bits 4:3, pattern 100, bit 6 zero.
// RQ8 - Enable-receive arms reception into the page, clears receiver inhibited.
// RQ9 - Enable-receive bit 5 adds 256 bytes to the buffer start.
// RQ10 - Enable-receive bit 7 also accepts broadcasts to identifier zero.
// RQ11 - Successful message reception sets receiver inhibited.
// RQ12 - Enable-transmit arms transmission from page at next token.
// RQ13 - Enable-transmit bit 5 starts the buffer 256 bytes into the page.
// RQ14 - Enable-transmit clears transmitter available and transmit acked.
// RQ15 - Transmit completion sets transmitter available.
// RQ16 - Transmit acked is set before transmitter available when acked.
// RQ17 - Acknowledges are made by hardware before the host learns of it.
// RQ18 - Define-configuration bit 3 selects long and short or short only.
// RQ19 - Clear-flags bit 3 clears power-on and excess nack flags.
// RQ20 - Clear-flags bit 4 clears the reconfiguration flag.
// RQ21 - Undefined command bytes change nothing.
module tnc_decoder (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // AHB-Lite slave.
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Protocol engine events.
  input  wire logic        i_token_rx,
  input  wire logic        i_rx_start,
  input  wire logic        i_rx_done_ok,
  input  wire logic        i_tx_ack_rx,
  input  wire logic        i_tx_done,
  input  wire logic        i_por_event,
  input  wire logic        i_excess_nack,
  input  wire logic        i_reconfig,
  // Controls to the protocol engine.
  output logic             o_tx_start,
  output logic             o_rx_armed,
  output logic             o_rx_bcast,
  output logic      [10:0] o_rx_base,
  output logic      [10:0] o_tx_base,
  output logic             o_long_pkts,
  output logic             o_chain_clr_tx,
  output logic             o_chain_clr_rx,
  // Status.
  output logic             o_transmitter_available_flag,
  output logic             o_transmit_acked_flag,
  output logic             o_receiver_inhibited_flag,
  output logic             o_por_flag,
  output logic             o_excess_nack_flag,
  output logic             o_reconfig_flag
);
  //////////////////////////////////////////////////////////////////////////////
  // Bus slave. Zero wait states; writes land at the data phase.
  logic        ph_wr;
  logic [3:0]  ph_addr;
  logic        chain_en;
  logic        rx_busy;
  wire         addr_ok = i_hsel && i_htrans[1] && i_hready;
  // Only the low sixteen bytes are decoded; a stray access above them is
  // dropped so that it cannot alias onto the command register.
  wire         in_map  = (i_haddr[31:4] == 28'h0);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_wr   <= 1'b0;
      ph_addr <= 4'h0;
    end else begin
      ph_wr   <= addr_ok && i_hwrite && in_map;
      ph_addr <= i_haddr[3:0];
    end
  end
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  wire cmd_wr  = ph_wr && (ph_addr == `TNC_ADDR_CMD);
  wire ctrl_wr = ph_wr && (ph_addr == `TNC_ADDR_CTRL);
  wire [7:0] cmd = i_hwdata[7:0];
  wire [31:0] status_word = {22'h0, rx_busy, o_reconfig_flag,
    o_excess_nack_flag, o_por_flag, o_long_pkts, o_rx_armed,
    o_receiver_inhibited_flag, o_transmit_acked_flag,
    o_transmitter_available_flag, chain_en};
  wire [31:0] rd_mux =
    !in_map                             ? 32'h0 :
    (i_haddr[3:0] == `TNC_ADDR_STATUS) ? status_word :
    (i_haddr[3:0] == `TNC_ADDR_CTRL)   ? {31'h0, chain_en} :
    (i_haddr[3:0] == `TNC_ADDR_TXPTR)  ? {21'h0, o_tx_base} : 32'h0;
  // The read word is captured in the address phase and stands through the
  // whole data phase, so the master finds it at the edge that ends it.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hrdata <= 32'h0;
    end else if (addr_ok && !i_hwrite) begin
      o_hrdata <= rd_mux;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chain_en <= `TNC_RST_CTRL;
    end else if (ctrl_wr) begin
      chain_en <= i_hwdata[0];
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Command classification.
  tnc_pkg::tnc_cmd_type kind;
  tnc_cmd_classify u_cls (
    .i_byte     (cmd),
    .i_chain_en (chain_en),
    .o_kind     (kind)
  );
  wire k_dis_tx = cmd_wr && (kind == tnc_pkg::CMD_DIS_TX);
  wire k_dis_rx = cmd_wr && (kind == tnc_pkg::CMD_DIS_RX);
  wire k_en_rx  = cmd_wr && (kind == tnc_pkg::CMD_EN_RX);
  wire k_en_tx  = cmd_wr && (kind == tnc_pkg::CMD_EN_TX);
  wire k_cfg    = cmd_wr && (kind == tnc_pkg::CMD_CFG);
  wire k_clr    = cmd_wr && (kind == tnc_pkg::CMD_CLR);
  wire k_chain  = cmd_wr && (kind == tnc_pkg::CMD_CHAIN);
  wire [10:0] page_base = {cmd[4:3], 9'h0} +
    (cmd[`TNC_BIT_OFFS] ? `TNC_PAGE_BYTES : 11'h0); // RQ9 RQ13
  //////////////////////////////////////////////////////////////////////////////
  // Transmit side.
  tnc_pkg::tnc_tx_state_type tx_state;
  tnc_pkg::tnc_tx_state_type next_tx_state;
  logic tx_dis_pend;
  always_comb begin
    next_tx_state = tx_state;
    unique case (tx_state)
      tnc_pkg::TX_IDLE: begin
        if (k_en_tx) next_tx_state = tnc_pkg::TX_ARMED; // RQ12
      end
      tnc_pkg::TX_ARMED: begin
        if (k_dis_tx) next_tx_state = tnc_pkg::TX_IDLE; // RQ2
        else if (i_token_rx) next_tx_state = tnc_pkg::TX_SEND;
      end
      tnc_pkg::TX_SEND: begin
        if (i_tx_done) next_tx_state = tnc_pkg::TX_IDLE;
      end
      default: next_tx_state = tnc_pkg::TX_IDLE;
    endcase
  end
  assign o_tx_start = (tx_state == tnc_pkg::TX_ARMED) && i_token_rx &&
                      !k_dis_tx;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_state  <= tnc_pkg::TX_IDLE;
      o_tx_base <= 11'h0;
    end else begin
      tx_state  <= next_tx_state;
      if (k_en_tx && tx_state == tnc_pkg::TX_IDLE) o_tx_base <= page_base;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_dis_pend <= 1'b0;
    end else if (k_dis_tx) begin
      tx_dis_pend <= 1'b1;
    end else if (i_token_rx || k_en_tx) begin
      tx_dis_pend <= 1'b0;
    end
  end
  // Completion sets available; an ack earlier in the sequence sets acked.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_transmitter_available_flag <= 1'b1;
      o_transmit_acked_flag        <= 1'b0;
    end else begin
      if ((tx_state == tnc_pkg::TX_SEND && i_tx_done) ||
          (tx_dis_pend && i_token_rx)) begin
        o_transmitter_available_flag <= 1'b1; // RQ3 RQ15
      end else if (k_en_tx) begin
        o_transmitter_available_flag <= 1'b0; // RQ14
      end
      if (tx_state == tnc_pkg::TX_SEND && i_tx_ack_rx) begin
        o_transmit_acked_flag <= 1'b1; // RQ16 RQ17
      end else if (k_en_tx) begin
        o_transmit_acked_flag <= 1'b0; // RQ14
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Receive side. A reception in flight is not aborted by disable.
  logic rx_dis_pend;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx_armed  <= 1'b0;
      o_rx_bcast  <= 1'b0;
      o_rx_base   <= 11'h0;
      rx_busy     <= 1'b0;
      rx_dis_pend <= 1'b0;
    end else begin
      if (k_en_rx) begin
        o_rx_armed <= 1'b1; // RQ7 RQ8
        o_rx_bcast <= cmd[`TNC_BIT_BCAST]; // RQ10
        o_rx_base  <= page_base;
      end else if (k_dis_rx || i_rx_done_ok) begin
        o_rx_armed <= 1'b0; // RQ4
      end
      if (i_rx_start && o_rx_armed) rx_busy <= 1'b1;
      else if (i_rx_done_ok) rx_busy <= 1'b0; // RQ6
      if (k_dis_rx && !rx_busy) rx_dis_pend <= 1'b1; // RQ5
      else if (i_token_rx || k_en_rx) rx_dis_pend <= 1'b0;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_receiver_inhibited_flag <= 1'b1;
    end else if ((i_rx_done_ok && rx_busy) ||
                 (rx_dis_pend && i_token_rx)) begin
      o_receiver_inhibited_flag <= 1'b1; // RQ5 RQ11
    end else if (k_en_rx) begin
      o_receiver_inhibited_flag <= 1'b0; // RQ8
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Configuration, chain pulses and clearable flags; set beats clear.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_long_pkts        <= 1'b0;
      o_chain_clr_tx     <= 1'b0;
      o_chain_clr_rx     <= 1'b0;
      o_por_flag         <= 1'b1;
      o_excess_nack_flag <= 1'b0;
      o_reconfig_flag    <= 1'b0;
    end else begin
      if (k_cfg) o_long_pkts <= cmd[`TNC_BIT_CFG_LONG]; // RQ18
      o_chain_clr_tx <= k_chain && !cmd[3]; // RQ1
      o_chain_clr_rx <= k_chain && cmd[3]; // RQ1
      if (i_por_event) o_por_flag <= 1'b1;
      else if (k_clr && cmd[`TNC_BIT_CLR_POR]) o_por_flag <= 1'b0; // RQ19
      if (i_excess_nack) o_excess_nack_flag <= 1'b1;
      else if (k_clr && cmd[`TNC_BIT_CLR_POR]) begin
        o_excess_nack_flag <= 1'b0; // RQ19
      end
      if (i_reconfig) o_reconfig_flag <= 1'b1;
      else if (k_clr && cmd[`TNC_BIT_CLR_RECONFIG_FLAG]) begin
        o_reconfig_flag <= 1'b0; // RQ20
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Assertions.
  sequence s_en_tx;
    k_en_tx && !i_tx_done && !i_token_rx;
  endsequence
  property p_en_tx_clears;
    @(posedge i_clk) disable iff (!i_rst_n)
      (s_en_tx and (tx_state == tnc_pkg::TX_IDLE)) |=>
        !o_transmitter_available_flag && !o_transmit_acked_flag;
  endproperty
  a_en_tx_clears: assert property (p_en_tx_clears) // RQ14
    else $error("enable transmit did not clear flags");
  property p_tx_done_sets;
    @(posedge i_clk) disable iff (!i_rst_n)
      tx_state == tnc_pkg::TX_SEND && i_tx_done |=>
        o_transmitter_available_flag && tx_state == tnc_pkg::TX_IDLE;
  endproperty
  a_tx_done_sets: assert property (p_tx_done_sets) // RQ15
    else $error("transmit done did not set available");
  property p_dis_tx_cancel;
    @(posedge i_clk) disable iff (!i_rst_n)
      tx_state == tnc_pkg::TX_ARMED && k_dis_tx |=>
        tx_state == tnc_pkg::TX_IDLE;
  endproperty
  a_dis_tx_cancel: assert property (p_dis_tx_cancel) // RQ2
    else $error("disable transmit did not cancel");
  property p_dis_tx_token;
    @(posedge i_clk) disable iff (!i_rst_n)
      tx_dis_pend && i_token_rx |=> o_transmitter_available_flag;
  endproperty
  a_dis_tx_token: assert property (p_dis_tx_token) // RQ3
    else $error("token after disable did not set available");
  property p_en_rx;
    @(posedge i_clk) disable iff (!i_rst_n)
      k_en_rx && !i_rx_done_ok && !i_token_rx |=>
        o_rx_armed && !o_receiver_inhibited_flag &&
        o_rx_bcast == $past(cmd[7]);
  endproperty
  a_en_rx: assert property (p_en_rx) // RQ8
    else $error("enable receive not applied");
  property p_rx_ok;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_rx_done_ok && rx_busy |=> o_receiver_inhibited_flag;
  endproperty
  a_rx_ok: assert property (p_rx_ok) // RQ11
    else $error("good reception did not set inhibited");
  property p_dis_rx;
    @(posedge i_clk) disable iff (!i_rst_n)
      k_dis_rx && !k_en_rx |=> !o_rx_armed;
  endproperty
  a_dis_rx: assert property (p_dis_rx) // RQ4
    else $error("disable receive did not cancel");
  property p_undef;
    @(posedge i_clk) disable iff (!i_rst_n)
      cmd_wr && kind == tnc_pkg::CMD_NONE && !i_token_rx && !i_tx_done &&
        !i_rx_done_ok && !i_rx_start |=> $stable(o_rx_armed) &&
        $stable(tx_state) && $stable(o_long_pkts);
  endproperty
  a_undef: assert property (p_undef) // RQ21
    else $error("undefined command changed state");
  property p_chain_off;
    @(posedge i_clk) disable iff (!i_rst_n)
      cmd_wr && !chain_en |=> !o_chain_clr_tx && !o_chain_clr_rx;
  endproperty
  a_chain_off: assert property (p_chain_off) // RQ1
    else $error("interrupt clear acted on without chaining");
  property p_cfg;
    @(posedge i_clk) disable iff (!i_rst_n)
      k_cfg |=> o_long_pkts == $past(cmd[`TNC_BIT_CFG_LONG]);
  endproperty
  a_cfg: assert property (p_cfg) // RQ18
    else $error("configuration not applied");
  property p_clr_por;
    @(posedge i_clk) disable iff (!i_rst_n)
      k_clr && cmd[`TNC_BIT_CLR_POR] && !i_por_event && !i_excess_nack |=>
        !o_por_flag && !o_excess_nack_flag;
  endproperty
  a_clr_por: assert property (p_clr_por) // RQ19
    else $error("clear flags left power-on or nack flag set");
  property p_clr_reconfig_flag;
    @(posedge i_clk) disable iff (!i_rst_n)
      k_clr && cmd[`TNC_BIT_CLR_RECONFIG_FLAG] && !i_reconfig |=> !o_reconfig_flag;
  endproperty
  a_clr_reconfig_flag: assert property (p_clr_reconfig_flag) // RQ20
    else $error("clear flags left reconfiguration flag set");
  property p_rx_finish;
    @(posedge i_clk) disable iff (!i_rst_n)
      rx_busy && k_dis_rx && !i_rx_done_ok |=> rx_busy;
  endproperty
  a_rx_finish: assert property (p_rx_finish) // RQ6
    else $error("disable receive aborted a reception");
endmodule : tnc_decoder

// *** tnc_regs.svh ***
`ifndef TNC_REGS_SVH
`define TNC_REGS_SVH
// Command byte encodings and field positions.
`define TNC_CMD_CLR_TX_INT  8'h00
`define TNC_CMD_DIS_TX      8'h01
`define TNC_CMD_DIS_RX      8'h02
`define TNC_CMD_CLR_RX_INT  8'h08
`define TNC_RX_PAT          3'h4
`define TNC_TX_PAT          3'h3
`define TNC_CFG_PAT         3'h5
`define TNC_CLR_PAT         3'h6
`define TNC_BIT_BCAST       7
`define TNC_BIT_OFFS        5
`define TNC_BIT_CFG_LONG    3
`define TNC_BIT_CLR_POR     3
`define TNC_BIT_CLR_RECONFIG_FLAG   4
`define TNC_PAGE_BYTES      11'h100
// Register map on the bus (byte addresses).
`define TNC_ADDR_CMD        4'h0
`define TNC_ADDR_STATUS     4'h4
`define TNC_ADDR_CTRL       4'h8
`define TNC_ADDR_TXPTR      4'hC
// Reset values.
`define TNC_RST_CTRL        1'b0
`endif

// *** tnc_pkg.sv ***
package tnc_pkg;
  typedef enum logic [2:0] {
    CMD_NONE, CMD_DIS_TX, CMD_DIS_RX, CMD_EN_RX, CMD_EN_TX,
    CMD_CFG, CMD_CLR, CMD_CHAIN
  } tnc_cmd_type;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_ARMED = 2'b01,
    TX_SEND = 2'b11
  } tnc_tx_state_type;
endpackage : tnc_pkg

// *** tnc_cmd_classify.sv ***
`timescale 1ns/100ps
`include "tnc_regs.svh"
module tnc_cmd_classify (
  // Command byte in.
  input  wire logic [7:0]          i_byte,
  input  wire logic                i_chain_en,
  // Decoded kind.
  output tnc_pkg::tnc_cmd_type     o_kind
);
  wire is_rx    = (i_byte[2:0] == `TNC_RX_PAT) && !i_byte[6];
  wire is_tx    = (i_byte[2:0] == `TNC_TX_PAT) && (i_byte[7:6] == 2'b00);
  wire is_cfg   = (i_byte[2:0] == `TNC_CFG_PAT) && (i_byte[7:4] == 4'h0);
  wire is_clr   = (i_byte[2:0] == `TNC_CLR_PAT) && (i_byte[7:5] == 3'h0);
  wire is_chain = i_chain_en && ((i_byte == `TNC_CMD_CLR_TX_INT) ||
                  (i_byte == `TNC_CMD_CLR_RX_INT)); // RQ1
  assign o_kind = (i_byte == `TNC_CMD_DIS_TX) ? tnc_pkg::CMD_DIS_TX :
                  (i_byte == `TNC_CMD_DIS_RX) ? tnc_pkg::CMD_DIS_RX :
                  is_rx    ? tnc_pkg::CMD_EN_RX :
                  is_tx    ? tnc_pkg::CMD_EN_TX :
                  is_cfg   ? tnc_pkg::CMD_CFG :
                  is_clr   ? tnc_pkg::CMD_CLR :
                  is_chain ? tnc_pkg::CMD_CHAIN :
                  tnc_pkg::CMD_NONE; // RQ21
endmodule : tnc_cmd_classify

// *** tnc_host_model.sv ***
`timescale 1ns/100ps
module tnc_host_model (
  // Bus clock and answer.
  input  wire logic        i_clk,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hrdata,
  // Request.
  output logic             o_hsel,
  output logic      [31:0] o_haddr,
  output logic      [1:0]  o_htrans,
  output logic             o_hwrite,
  output logic      [2:0]  o_hsize,
  output logic      [31:0] o_hwdata
);
  initial begin
    o_hsel   = 1'b0;
    o_haddr  = 32'h0000_0000;
    o_htrans = 2'b00;
    o_hwrite = 1'b0;
    o_hsize  = 3'b010;
    o_hwdata = 32'h0000_0000;
  end

  // Stale write data is inverted so a slave that samples early never sees it.
  task automatic xfer(input logic wr, input logic [31:0] addr,
                      input logic [31:0] data, output logic [31:0] rd);
    @(posedge i_clk);
    o_hsel   <= 1'b1;
    o_haddr  <= addr;
    o_htrans <= 2'b10;
    o_hwrite <= wr;
    o_hsize  <= 3'b010;
    o_hwdata <= ~o_hwdata;
    do @(posedge i_clk); while (i_hready !== 1'b1);
    o_htrans <= 2'b00;
    o_hwdata <= data;
    do @(posedge i_clk); while (i_hready !== 1'b1);
    rd = i_hrdata;
  endtask : xfer
endmodule : tnc_host_model

// *** tb.sv ***
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb;
  logic        i_clk, i_rst_n, hsel, hwrite, hrdy, hresp;
  logic [7:0]  ev;
  logic [31:0] rd, haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        tx_start, rx_armed, bcast, long_pkts, ctx, crx;
  logic [10:0] rx_base, tx_base;
  wire  [5:0]  flg;
  int          fails, n_checks, cyc, n_start, n_ctx, n_crx;

  tnc_host_model host_u (.i_clk(i_clk), .i_hready(hrdy), .i_hrdata(hrdata),
    .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite),
    .o_hsize(hsize), .o_hwdata(hwdata));
  tnc_decoder dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
    .o_hreadyout(hrdy), .o_hresp(hresp), .i_token_rx(ev[0]),
    .i_rx_start(ev[1]), .i_rx_done_ok(ev[2]), .i_tx_ack_rx(ev[3]),
    .i_tx_done(ev[4]), .i_por_event(ev[5]), .i_excess_nack(ev[6]),
    .i_reconfig(ev[7]), .o_tx_start(tx_start), .o_rx_armed(rx_armed),
    .o_rx_bcast(bcast), .o_rx_base(rx_base), .o_tx_base(tx_base),
    .o_long_pkts(long_pkts), .o_chain_clr_tx(ctx), .o_chain_clr_rx(crx),
    .o_transmitter_available_flag(flg[5]), .o_transmit_acked_flag(flg[4]),
    .o_receiver_inhibited_flag(flg[3]), .o_por_flag(flg[2]),
    .o_excess_nack_flag(flg[1]), .o_reconfig_flag(flg[0]));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // Pulses are counted on every rising edge so none slips between two checks.
  always @(posedge i_clk) begin
    cyc++;
    if (tx_start === 1'b1) n_start++;
    if (ctx === 1'b1) n_ctx++;
    if (crx === 1'b1) n_crx++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  task automatic settle;
    @(posedge i_clk);
    #1;
  endtask : settle

  task automatic wr(input logic [31:0] a, input logic [7:0] c);
    host_u.xfer(1'b1, a, {24'ha5_a5a5, c}, rd);
    settle();
  endtask : wr

  task automatic pulse(input int b);
    @(posedge i_clk);
    ev <= 8'h01 << b;
    @(posedge i_clk);
    ev <= 8'h00;
    settle();
  endtask : pulse
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_tx;
    logic [7:0]  c[2] = '{8'h2b, 8'h1b};
    logic [10:0] b[2] = '{11'h300, 11'h600};
    int          n;
    for (int i = 0; i < 2; i++) begin
      wr(32'h0000_0000, c[i]);
      `CHK("tx base", b[i], tx_base)
      `CHK("ta tma", 2'b00, flg[5:4])
      n = n_start;
      pulse(0);
      `CHK("tx start", 1, n_start - n)
      pulse(3);
      `CHK("ta tma", 2'b01, flg[5:4])
      pulse(4);
      `CHK("ta tma", 2'b11, flg[5:4])
    end
    host_u.xfer(1'b0, 32'h0000_000c, 32'h0000_0000, rd);
    `CHK("tx pointer", 32'h0000_0600, rd)
  endtask : t_tx

  task automatic t_txdis;
    int n;
    wr(32'h0000_0000, 8'h03);
    wr(32'h0000_0000, 8'h01);
    `CHK("ta", 1'b0, flg[5])
    n = n_start;
    pulse(0);
    `CHK("tx start", 0, n_start - n)
    `CHK("ta", 1'b1, flg[5])
  endtask : t_txdis

  task automatic t_rx;
    logic [7:0]  c[2] = '{8'hb4, 8'h0c};
    logic [10:0] b[2] = '{11'h500, 11'h200};
    for (int i = 0; i < 2; i++) begin
      wr(32'h0000_0000, c[i]);
      `CHK("armed ri", 2'b10, {rx_armed, flg[3]})
      `CHK("rx base", b[i], rx_base)
      `CHK("bcast", c[i][7], bcast)
      pulse(1);
      pulse(2);
      `CHK("ri", 1'b1, flg[3])
    end
  endtask : t_rx

  task automatic t_rxdis;
    wr(32'h0000_0000, 8'h04);
    wr(32'h0000_0000, 8'h02);
    `CHK("armed ri", 2'b00, {rx_armed, flg[3]})
    pulse(0);
    `CHK("ri", 1'b1, flg[3])
    wr(32'h0000_0000, 8'h04);
    pulse(1);
    wr(32'h0000_0000, 8'h02);
    `CHK("armed", 1'b0, rx_armed)
    pulse(0);
    `CHK("ri", 1'b0, flg[3])
    pulse(2);
    `CHK("ri", 1'b1, flg[3])
  endtask : t_rxdis

  task automatic t_cfg_clr;
    wr(32'h0000_0000, 8'h0d);
    `CHK("long", 1'b1, long_pkts)
    wr(32'h0000_0000, 8'h05);
    `CHK("long", 1'b0, long_pkts)
    pulse(6);
    pulse(7);
    wr(32'h0000_0000, 8'h0e);
    `CHK("por exc reconfig_flag", 3'b001, flg[2:0])
    wr(32'h0000_0000, 8'h16);
    `CHK("por exc reconfig_flag", 3'b000, flg[2:0])
  endtask : t_cfg_clr

  task automatic t_chain;
    int n;
    int m;
    n = n_ctx;
    m = n_crx;
    wr(32'h0000_0000, 8'h00);
    wr(32'h0000_0000, 8'h08);
    `CHK("clear pulses", 0, n_ctx - n + n_crx - m)
    // The host issues the clear codes again once chaining is switched on.
    wr(32'h0000_0008, 8'h01);
    host_u.xfer(1'b0, 32'h0000_0008, 32'h0000_0000, rd);
    `CHK("chain enable", 32'h0000_0001, rd)
    wr(32'h0000_0000, 8'h00);
    `CHK("clear tx", 1, n_ctx - n)
    wr(32'h0000_0000, 8'h08);
    `CHK("clear rx", 1, n_crx - m)
    wr(32'h0000_0008, 8'h00);
  endtask : t_chain

  task automatic t_undef;
    logic [6:0] s;
    s = {rx_armed, flg};
    wr(32'h0000_0000, 8'hff);
    wr(32'h0000_0000, 8'h07);
    wr(32'h0000_0000, 8'h4c);
    wr(32'h0000_0010, 8'h04);
    `CHK("state", s, {rx_armed, flg})
    host_u.xfer(1'b0, 32'h0000_0010, 32'h0000_0000, rd);
    `CHK("read unmapped", 32'h0000_0000, rd)
    `CHK("resp", 1'b0, hresp)
    `CHK("ready", 1'b1, hrdy)
    host_u.xfer(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
    `CHK("status", 32'h0000_000a, rd)
  endtask : t_undef

  initial begin
    i_rst_n = 1'b0;
    ev = 8'h00;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    settle();
    `CHK("reset flags", 6'b101100, flg)
    t_tx();
    t_txdis();
    t_rx();
    t_rxdis();
    t_cfg_clr();
    t_chain();
    t_undef();
    final_report();
  end
endmodule : tb
